// [design/fbm_pkg.sv]
// How it works
// - A read holds select and output gate low, write strobe high.
// - A command cycle holds strobe and select low, output gate high.
// - Short program mode needs two write cycles per word, not four.
// - One write-buffer operation takes at most 16 words.
// - High voltage is applied only during accelerated programming.
// - Work aborted by hardware reset should be restarted afterwards.
package fbm_pkg;

  localparam int ADDR_W        = 20;
  localparam int DATA_W        = 16;
  localparam int ID_W          = 8;
  localparam int PAGE_SEL_W    = 2;
  localparam int PAGE_WORDS    = 4;
  localparam int BUF_MAX_WORDS = 16;
  localparam int STD_PROG_CYC  = 4;
  localparam int SHORT_PROG_CYC = 2;
  localparam int SYNC_STAGES   = 2;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS   = 10;
  localparam int T_ADDR_ACC_NS   = 90;
  localparam int T_PAGE_ACC_NS   = 25;
  localparam int T_SLEEP_EXTRA_NS = 30;
  localparam int T_RST_PULSE_NS  = 500;
  localparam int T_RST_REC_NS    = 50;
  localparam int T_WE_PULSE_NS   = 35;
  localparam int T_SETUP_NS      = 10;

  function automatic int cyclesUp(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int ACC_CYC   = cyclesUp(T_ADDR_ACC_NS);
  localparam int PACC_CYC  = cyclesUp(T_PAGE_ACC_NS);
  localparam int SLEEP_CYC = cyclesUp(T_ADDR_ACC_NS + T_SLEEP_EXTRA_NS);
  localparam int RP_CYC    = cyclesUp(T_RST_PULSE_NS);
  localparam int RH_CYC    = cyclesUp(T_RST_REC_NS);
  localparam int WP_CYC    = cyclesUp(T_WE_PULSE_NS);
  localparam int SETUP_CYC = cyclesUp(T_SETUP_NS);

  // ---------------------------------------------------------------
  // Command words (arbitrary values, set per target part)
  // ---------------------------------------------------------------
  localparam logic [ADDR_W-1:0] CMD_ADDR_A      = 20'h00555;
  localparam logic [ADDR_W-1:0] CMD_ADDR_B      = 20'h002AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_A    = 16'h00AA;
  localparam logic [DATA_W-1:0] CMD_UNLOCK_B    = 16'h0055;
  localparam logic [DATA_W-1:0] CMD_PROG        = 16'h00A0;
  localparam logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080;
  localparam logic [DATA_W-1:0] CMD_ERASE_SECT  = 16'h0030;
  localparam logic [DATA_W-1:0] CMD_ERASE_CHIP  = 16'h0010;
  localparam logic [DATA_W-1:0] CMD_AUTOSEL     = 16'h0090;

  typedef enum logic [2:0] {
    OP_READ       = 3'h0,
    OP_WRITE      = 3'h1,
    OP_PROG       = 3'h2,
    OP_ERASE_SECT = 3'h3,
    OP_ERASE_CHIP = 3'h4,
    OP_AUTOSEL    = 3'h5,
    OP_BUF_WORD   = 3'h6,
    OP_HWRESET    = 3'h7
  } fbm_op_e;

  typedef struct packed {
    fbm_op_e             op;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } fbm_req_s;

  typedef struct packed {
    logic                ceN;
    logic                oeN;
    logic                weN;
    logic                resetN;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dqOut;
    logic                dqOe;
  } fbm_pins_s;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                last;
  } fbm_cyc_s;

endpackage

// [design/fbm_sync2.sv]
`timescale 1ns/1ns
module fbm_sync2 #(
  parameter int W = 16
) (
  // Clock and reset
  input  wire logic         sys_clk,
  input  wire logic         arst_n,
  input  wire logic         clkEn,
  // Data
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;
  logic [W-1:0] meta_d;
  logic [W-1:0] stab_q;
  logic [W-1:0] stab_d;

  always_comb begin
    meta_d = clkEn ? din : meta_q;
    stab_d = clkEn ? meta_q : stab_q;
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_q <= '0;
      stab_q <= '0;
    end else begin
      meta_q <= meta_d;
      stab_q <= stab_d;
    end
  end

  assign dout = stab_q;

endmodule

// [design/fbm_host.sv]
`timescale 1ns/1ns
module fbm_host
  import fbm_pkg::*;
#(
  parameter int STANDBY_IDLE_CYC = 16
) (
  // Clock and reset
  input  wire logic                      sys_clk,
  input  wire logic                      arst_n,
  input  wire logic                      clkEn,
  // User requests
  input  wire logic                      reqValid,
  input  wire fbm_pkg::fbm_req_s         req,
  output logic                           reqReady,
  input  wire logic                      accelReq,
  input  wire logic                      protectReq,
  // User answers
  output logic                           rspValid,
  output logic                           rspErr,
  output logic [fbm_pkg::DATA_W-1:0]     rspData,
  output logic                           resetDone,
  // Flash pins
  output fbm_pkg::fbm_pins_s             pins,
  input  wire logic [fbm_pkg::DATA_W-1:0] dqIn,
  output logic                           hvEn,
  output logic                           protOut,
  output logic                           protOe
);

  if (STANDBY_IDLE_CYC < 1 || STANDBY_IDLE_CYC > 65535) begin : g_chk
    $error("STANDBY_IDLE_CYC out of range");
  end

  typedef enum logic [6:0] {
    S_IDLE   = 7'b0000001,
    S_RST    = 7'b0000010,
    S_RSTREC = 7'b0000100,
    S_RD     = 7'b0001000,
    S_WSET   = 7'b0010000,
    S_WPULSE = 7'b0100000,
    S_WHOLD  = 7'b1000000
  } fbm_state_e;

  // ---------------------------------------------------------------
  // Command sequences
  // ---------------------------------------------------------------
  function automatic fbm_cyc_s seqCycle(input fbm_op_e op,
                                        input logic [2:0] step,
                                        input logic shortSeq,
                                        input fbm_req_s r);
    fbm_cyc_s c;
    c = '{addr: r.addr, data: r.data, last: 1'b1};
    case (op)
      OP_PROG: begin
        if (shortSeq) begin
          if (step == 3'd0) c = '{CMD_ADDR_A, CMD_PROG, 1'b0};
        end else begin
          case (step)
            3'd0: c = '{CMD_ADDR_A, CMD_UNLOCK_A, 1'b0};
            3'd1: c = '{CMD_ADDR_B, CMD_UNLOCK_B, 1'b0};
            3'd2: c = '{CMD_ADDR_A, CMD_PROG, 1'b0};
            default: c = '{r.addr, r.data, 1'b1};
          endcase
        end
      end
      OP_ERASE_SECT, OP_ERASE_CHIP: begin
        case (step)
          3'd0, 3'd3: c = '{CMD_ADDR_A, CMD_UNLOCK_A, 1'b0};
          3'd1, 3'd4: c = '{CMD_ADDR_B, CMD_UNLOCK_B, 1'b0};
          3'd2: c = '{CMD_ADDR_A, CMD_ERASE_SETUP, 1'b0};
          default: begin
            // Sector or whole array; more sectors via OP_WRITE
            if (op == OP_ERASE_CHIP) c = '{CMD_ADDR_A, CMD_ERASE_CHIP, 1'b1};
            else c = '{r.addr, CMD_ERASE_SECT, 1'b1};
          end
        endcase
      end
      OP_AUTOSEL: begin
        case (step)
          3'd0: c = '{CMD_ADDR_A, CMD_UNLOCK_A, 1'b0};
          3'd1: c = '{CMD_ADDR_B, CMD_UNLOCK_B, 1'b0};
          default: c = '{CMD_ADDR_A, CMD_AUTOSEL, 1'b1};
        endcase
      end
      default: c = '{r.addr, r.data, 1'b1};
    endcase
    return c;
  endfunction

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  fbm_state_e              state_q, state_d;
  fbm_pins_s               pins_q, pins_d;
  fbm_req_s                cur_q, cur_d;
  logic [15:0]             cnt_q, cnt_d;
  logic [15:0]             idle_q, idle_d;
  logic [2:0]              step_q, step_d;
  logic [4:0]              bufCnt_q, bufCnt_d;
  logic                    pageOpen_q, pageOpen_d;
  logic                    idMode_q, idMode_d;
  logic                    short_q, short_d;
  logic                    hv_q, hv_d;
  logic                    rspV_q, rspV_d;
  logic                    rspE_q, rspE_d;
  logic [DATA_W-1:0]       rspD_q, rspD_d;
  logic                    rstDone_q, rstDone_d;
  logic                    prot_q, prot_d;
  logic [DATA_W-1:0]       dqSync;
  logic                    pageHit;
  fbm_cyc_s                cyc;
  fbm_cyc_s                curCyc;

  fbm_sync2 #(.W(DATA_W)) uDqSync (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .clkEn   (clkEn),
    .din     (dqIn),
    .dout    (dqSync)
  );

  // Page hit only while select has stayed low since the last read
  assign pageHit = pageOpen_q && !pins_q.ceN &&
                   (req.addr[ADDR_W-1:PAGE_SEL_W] ==
                    pins_q.addr[ADDR_W-1:PAGE_SEL_W]);
  assign cyc = seqCycle(state_q == S_IDLE ? req.op : cur_q.op,
                        state_q == S_IDLE ? 3'd0 : step_q + 3'd1,
                        state_q == S_IDLE ? accelReq : short_q,
                        state_q == S_IDLE ? req : cur_q);
  assign curCyc = seqCycle(cur_q.op, step_q, short_q, cur_q);

  always_comb begin
    state_d = state_q;  pins_d = pins_q;  cur_d = cur_q;
    cnt_d = cnt_q;  idle_d = idle_q;  step_d = step_q;
    bufCnt_d = bufCnt_q;  pageOpen_d = pageOpen_q;
    idMode_d = idMode_q;  short_d = short_q;  hv_d = hv_q;
    rspV_d = 1'b0;  rspE_d = 1'b0;  rspD_d = rspD_q;
    rstDone_d = 1'b0;
    prot_d = protectReq && !hv_q;
    case (state_q)
      S_IDLE: begin
        idle_d = (idle_q == 16'hFFFF) ? idle_q : idle_q + 16'd1;
        if (reqValid && req.op == OP_HWRESET) begin
          pins_d = '{1'b1, 1'b1, 1'b1, 1'b0, pins_q.addr, '0, 1'b0};
          cnt_d = 16'(RP_CYC);
          state_d = S_RST;
        end else if (reqValid && req.op == OP_READ) begin
          // Address held after the read so sleep keeps data latched
          pins_d.ceN = 1'b0;  pins_d.oeN = 1'b0;  pins_d.weN = 1'b1;
          pins_d.dqOe = 1'b0;
          pins_d.addr = req.addr;
          // Spare cycle: data is not sure at the access-time edge itself
          cnt_d = pageHit ? 16'(PACC_CYC + SYNC_STAGES + 1)
                          : 16'(ACC_CYC + SYNC_STAGES + 1);
          cur_d = req;
          state_d = S_RD;
        end else if (reqValid && req.op == OP_BUF_WORD &&
                     bufCnt_q == 5'(BUF_MAX_WORDS)) begin
          rspV_d = 1'b1;  rspE_d = 1'b1;
        end else if (reqValid) begin
          pins_d = '{1'b0, 1'b1, 1'b1, 1'b1, cyc.addr, cyc.data, 1'b1};
          cur_d = req;  step_d = 3'd0;
          short_d = accelReq && req.op == OP_PROG;
          hv_d = accelReq && req.op == OP_PROG;
          pageOpen_d = 1'b0;
          cnt_d = 16'(SETUP_CYC);
          state_d = S_WSET;
        end else if (idle_q >= 16'(STANDBY_IDLE_CYC)) begin
          pins_d.ceN = 1'b1;  pins_d.oeN = 1'b1;
          pageOpen_d = 1'b0;
        end
        if (reqValid) idle_d = '0;
      end
      S_RST: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          pins_d.resetN = 1'b1;
          cnt_d = 16'(RH_CYC);
          state_d = S_RSTREC;
        end
      end
      S_RSTREC: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          // Device is back in array read; tell user to retry work
          idMode_d = 1'b0;  bufCnt_d = '0;  pageOpen_d = 1'b0;
          rstDone_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_RD: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          rspD_d = idMode_q ? {{(DATA_W-ID_W){1'b0}}, dqSync[ID_W-1:0]}
                            : dqSync;
          rspV_d = 1'b1;
          pageOpen_d = 1'b1;
          state_d = S_IDLE;
        end
      end
      S_WSET: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          pins_d.weN = 1'b0;
          cnt_d = 16'(WP_CYC);
          state_d = S_WPULSE;
        end
      end
      S_WPULSE: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          pins_d.weN = 1'b1;
          cnt_d = 16'(SETUP_CYC);
          state_d = S_WHOLD;
        end
      end
      S_WHOLD: begin
        cnt_d = cnt_q - 16'd1;
        if (cnt_q == 16'd1) begin
          if (curCyc.last) begin
            // Array work runs on inside the device after this point
            pins_d.dqOe = 1'b0;
            hv_d = 1'b0;
            rspV_d = 1'b1;
            idMode_d = (cur_q.op == OP_AUTOSEL);
            if (cur_q.op == OP_BUF_WORD) bufCnt_d = bufCnt_q + 5'd1;
            else bufCnt_d = '0;
            idle_d = '0;
            state_d = S_IDLE;
          end else begin
            step_d = step_q + 3'd1;
            pins_d.addr = cyc.addr;  pins_d.dqOut = cyc.data;
            cnt_d = 16'(SETUP_CYC);
            state_d = S_WSET;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= S_RST;
      pins_q <= '{1'b1, 1'b1, 1'b1, 1'b0, '0, '0, 1'b0};
      cur_q <= '{OP_READ, '0, '0};
      cnt_q <= 16'(RP_CYC);
      idle_q <= '0;  step_q <= '0;  bufCnt_q <= '0;
      pageOpen_q <= 1'b0;  idMode_q <= 1'b0;  short_q <= 1'b0;
      hv_q <= 1'b0;  rspV_q <= 1'b0;  rspE_q <= 1'b0;  rspD_q <= '0;
      rstDone_q <= 1'b0;  prot_q <= 1'b0;
    end else if (clkEn) begin
      state_q <= state_d;  pins_q <= pins_d;  cur_q <= cur_d;
      cnt_q <= cnt_d;  idle_q <= idle_d;  step_q <= step_d;
      bufCnt_q <= bufCnt_d;  pageOpen_q <= pageOpen_d;
      idMode_q <= idMode_d;  short_q <= short_d;  hv_q <= hv_d;
      rspV_q <= rspV_d;  rspE_q <= rspE_d;  rspD_q <= rspD_d;
      rstDone_q <= rstDone_d;  prot_q <= prot_d;
    end
  end

  assign reqReady  = clkEn && state_q == S_IDLE;
  assign rspValid  = rspV_q;
  assign rspErr    = rspE_q;
  assign rspData   = rspD_q;
  assign resetDone = rstDone_q;
  assign pins      = pins_q;
  assign hvEn      = hv_q;
  // Protect pin released unless held low; its pull-up gives high
  assign protOut   = 1'b0;
  assign protOe    = prot_q;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic [15:0] rstLow_q, rdCnt_q;
  logic [3:0]  weFalls_q;
  logic        rdFull_q;
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      rstLow_q <= '0;  rdCnt_q <= '0;  weFalls_q <= '0;  rdFull_q <= 1'b0;
    end else if (clkEn) begin
      rstLow_q <= pins_q.resetN ? 16'd0 : rstLow_q + 16'd1;
      rdCnt_q <= (state_q == S_RD) ? rdCnt_q + 16'd1 : 16'd0;
      if (state_q == S_IDLE && state_d == S_RD) rdFull_q <= !pageHit;
      if (state_q == S_IDLE) weFalls_q <= '0;
      else if (state_q == S_WSET && state_d == S_WPULSE)
        weFalls_q <= weFalls_q + 4'd1;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!arst_n);

  a_read_pins: assert property (!pins.ceN && !pins.oeN |-> pins.weN)
    else $error("read with write strobe low");
  a_write_pins: assert property (!pins.weN |-> !pins.ceN && pins.oeN)
    else $error("write strobe without select or with gate low");
  a_gate_release: assert property (!pins.oeN |-> !pins.dqOe)
    else $error("host drives data while gate low");
  a_reset_width: assert property ($rose(pins.resetN) |->
                                  rstLow_q >= 16'(RP_CYC))
    else $error("reset pulse too short");
  a_hv_only_prog: assert property (hvEn |-> cur_q.op == OP_PROG)
    else $error("high voltage outside programming");
  a_buf_limit: assert property (bufCnt_q <= 5'(BUF_MAX_WORDS))
    else $error("write buffer overfilled");
  a_read_wait: assert property (clkEn && state_q == S_RD && state_d == S_IDLE
    |-> rdCnt_q + 16'd1 >= (rdFull_q ? 16'(ACC_CYC) : 16'(PACC_CYC)))
    else $error("read sampled too early");
  a_prog_cycles: assert property (clkEn && state_q == S_WHOLD &&
    state_d == S_IDLE && cur_q.op == OP_PROG |-> weFalls_q ==
    (short_q ? 4'(SHORT_PROG_CYC) : 4'(STD_PROG_CYC)))
    else $error("wrong program cycle count");
  a_id_byte: assert property (rspValid && idMode_q && !rspErr &&
    cur_q.op == OP_READ |->
    rspData[DATA_W-1:ID_W] == '0)
    else $error("identity read upper byte not zero");

  c_page_hit: cover property (state_q == S_RD && !rdFull_q ##1 rspValid);
  c_short_prog: cover property (hvEn && state_q == S_WHOLD ##1 !hvEn);
  c_hw_reset: cover property (resetDone);
  c_buf_refuse: cover property (rspErr);

endmodule

// [verif/fbm_flash_model.sv]
`timescale 1ns/1ns
module fbm_flash_model #(
  parameter logic [7:0] ID_CODE = 8'h5A  // Arbitrary value
) (
  // Host side
  input  wire fbm_pkg::fbm_pins_s          pins,
  input  wire logic                        hvEn,
  input  wire logic                        protOe,
  // Device side
  output logic [fbm_pkg::DATA_W-1:0]       dqIn,
  output logic                             protLevel,
  output logic                             hvAbuse
);
  import fbm_pkg::*;
  logic [DATA_W-1:0] mem [logic [ADDR_W-1:0]];
  logic [ADDR_W-1:0] prevA;
  logic              prevCe;
  logic              prevWe;
  logic              idMode;
  int                step;
  time               validAt;

  initial begin
    dqIn = '1;
    prevA = '0;
    prevCe = 1'b1;
    prevWe = 1'b1;
    idMode = 1'b0;
    step = 0;
    validAt = 0;
    hvAbuse = 1'b0;
  end

  assign protLevel = protOe ? 1'b0 : 1'b1;

  function automatic logic [DATA_W-1:0] rd(input logic [ADDR_W-1:0] a);
    if (idMode) return {8'h00, ID_CODE};
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction

  // Programming completes at once, so deselect never cuts it short
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    case (step)
      0: begin
        idMode = 1'b0;
        if (d == CMD_UNLOCK_A && a == CMD_ADDR_A) step = 1;
        else if (hvEn && d == CMD_PROG) step = 3;
      end
      1: step = (d == CMD_UNLOCK_B) ? 2 : 0;
      2: begin
        step = (d == CMD_PROG) ? 3 : (d == CMD_ERASE_SETUP) ? 4 : 0;
        idMode = (d == CMD_AUTOSEL);
      end
      3: begin
        mem[a] = d;
        step = 0;
      end
      4: step = (d == CMD_UNLOCK_A) ? 5 : 0;
      5: step = (d == CMD_UNLOCK_B) ? 6 : 0;
      default: begin
        if (d == CMD_ERASE_CHIP) mem.delete();
        else foreach (mem[k]) if (k[19:12] == a[19:12]) mem[k] = 16'hFFFF;
        step = 0;
      end
    endcase
  endtask

  always #1 begin
    if (!pins.resetN) begin
      step = 0;
      idMode = 1'b0;
    end else begin
      if (!prevWe && pins.weN && !pins.ceN && pins.oeN)
        wr(pins.addr, pins.dqOut);
      if (prevCe && !pins.ceN)
        validAt = $time + T_ADDR_ACC_NS;
      else if (pins.addr !== prevA)
        validAt = $time + ((pins.addr[19:2] == prevA[19:2] && !pins.ceN)
                  ? T_PAGE_ACC_NS : T_ADDR_ACC_NS);
    end
    if (hvEn && !pins.ceN && !pins.oeN) hvAbuse = 1'b1;
    // Released bus toggles so a stale value never looks valid
    if (!pins.resetN || pins.ceN || pins.oeN || $time < validAt)
      dqIn <= ~dqIn;
    else
      dqIn <= rd(pins.addr);
    prevA = pins.addr;
    prevCe = pins.ceN;
    prevWe = pins.weN;
  end
endmodule

// [verif/flash_bus_mode_control_bench.sv]
`timescale 1ns/1ns
module flash_bus_mode_control_bench;
  import fbm_pkg::*;
  localparam int         IDLE = 4;
  localparam logic [7:0] ID   = 8'h5A;  // Arbitrary value
  logic              sys_clk, arst_n, reqValid, reqReady, accelReq;
  logic              protectReq, rspValid, rspErr, resetDone, hvEn;
  logic              protOe, protOut, protLevel, hvAbuse;
  logic [DATA_W-1:0] rspData, dqIn;
  fbm_req_s          req;
  fbm_pins_s         pins;
  int                n_fail, num_checks, weFalls, hvSeen, fullLat, lat;

  fbm_host #(.STANDBY_IDLE_CYC(IDLE)) dut_u (
    .sys_clk(sys_clk), .arst_n(arst_n), .clkEn(1'b1), .reqValid(reqValid),
    .req(req), .reqReady(reqReady), .accelReq(accelReq),
    .protectReq(protectReq), .rspValid(rspValid), .rspErr(rspErr),
    .rspData(rspData), .resetDone(resetDone), .pins(pins), .dqIn(dqIn),
    .hvEn(hvEn), .protOut(protOut), .protOe(protOe));

  fbm_flash_model #(.ID_CODE(ID)) flash_u (
    .pins(pins), .hvEn(hvEn), .protOe(protOe), .dqIn(dqIn),
    .protLevel(protLevel), .hvAbuse(hvAbuse));

  always #5 sys_clk = ~sys_clk;

  always @(negedge pins.weN) begin
    weFalls++;
    if (hvEn) hvSeen++;
    chk({pins.ceN, pins.oeN}, 2'b01);
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, n_fail);
    if (n_fail == 0 && num_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic hang();
    n_fail++;
    $display("wait ran out at %0t", $time);
    complete_run();
  endtask

  // Entered and left at a falling edge; lat counts cycles to the answer
  task automatic do_op(input fbm_op_e op, input logic [ADDR_W-1:0] a,
                       input logic [DATA_W-1:0] d, output int lt);
    int i;
    weFalls = 0;
    hvSeen = 0;
    req = '{op: op, addr: a, data: d};
    reqValid = 1'b1;
    for (i = 0; i < 300 && !reqReady; i++) @(negedge sys_clk);
    if (!reqReady) hang();
    @(negedge sys_clk);
    reqValid = 1'b0;
    lt = 0;
    if (op == OP_HWRESET) return;
    for (lt = 1; lt < 300 && !rspValid; lt++) @(negedge sys_clk);
    if (!rspValid) hang();
  endtask

  task automatic wait_reset();
    int low, i;
    low = 0;
    for (i = 0; i < 300 && !resetDone; i++) begin
      @(negedge sys_clk);
      if (!pins.resetN) low++;
    end
    if (!resetDone) hang();
    chk(low >= RP_CYC - 1, 1);
    chk({pins.dqOe, pins.weN}, 2'b01);
    chk(reqReady, 1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_prog(input logic acc, input logic [ADDR_W-1:0] a,
                        input logic [DATA_W-1:0] d);
    accelReq = acc;
    do_op(OP_PROG, a, d, lat);
    chk(weFalls, acc ? SHORT_PROG_CYC : STD_PROG_CYC);
    chk(hvSeen, acc ? SHORT_PROG_CYC : 0);
    chk(hvEn, 0);
    accelReq = 1'b0;
    do_op(OP_READ, a, '0, lat);
    chk(rspData, d);
    chk(hvAbuse, 0);
    $display("program test done");
  endtask

  task automatic t_page();
    int h, m2;
    repeat (IDLE + 4) @(negedge sys_clk);
    chk({pins.ceN, pins.oeN}, 2'b11);
    do_op(OP_READ, 20'h00100, '0, fullLat);
    do_op(OP_READ, 20'h00103, '0, h);
    chk(fullLat - h, ACC_CYC - PACC_CYC);
    chk(rspData, 16'h1234);
    do_op(OP_READ, 20'h00104, '0, m2);
    chk(m2, fullLat);
    repeat (IDLE + 4) @(negedge sys_clk);
    do_op(OP_READ, 20'h00101, '0, m2);
    chk(m2, fullLat);
    chk({pins.ceN, pins.oeN, pins.weN}, 3'b001);
    $display("page test done");
  endtask

  task automatic t_buf();
    int i;
    for (i = 0; i <= BUF_MAX_WORDS; i++) begin
      do_op(OP_BUF_WORD, 20'h00200 + 20'(i), '0, lat);
      chk(rspErr, i == BUF_MAX_WORDS);
    end
    chk(weFalls, 0);
    $display("buffer test done");
  endtask

  task automatic t_auto();
    do_op(OP_AUTOSEL, '0, '0, lat);
    chk(weFalls, 3);
    do_op(OP_READ, 20'h00001, '0, lat);
    chk(rspData, {8'h00, ID});
    chk(lat, fullLat);
    do_op(OP_HWRESET, '0, '0, lat);
    wait_reset();
    do_op(OP_READ, 20'h00001, '0, lat);
    chk(rspData, 16'hFFFF);
    $display("identity test done");
  endtask

  task automatic t_erase();
    do_op(OP_ERASE_SECT, 20'h00000, '0, lat);
    chk(weFalls, 6);
    do_op(OP_READ, 20'h00103, '0, lat);
    chk(rspData, 16'hFFFF);
    do_op(OP_READ, 20'h12345, '0, lat);
    chk(rspData, 16'hC0DE);
    do_op(OP_ERASE_CHIP, '0, '0, lat);
    do_op(OP_READ, 20'h12345, '0, lat);
    chk(rspData, 16'hFFFF);
    protectReq = 1'b1;
    repeat (4) @(negedge sys_clk);
    chk(protLevel, 0);
    chk({protOe, protOut}, 2'b10);
    protectReq = 1'b0;
    repeat (4) @(negedge sys_clk);
    chk(protLevel, 1);
    $display("erase test done");
  endtask

  initial begin
    sys_clk = 1'b0;
    arst_n = 1'b0;
    reqValid = 1'b0;
    req = '0;
    accelReq = 1'b0;
    protectReq = 1'b0;
    n_fail = 0;
    num_checks = 0;
    weFalls = 0;
    hvSeen = 0;
    fullLat = 0;
    repeat (5) @(negedge sys_clk);
    chk({pins.resetN, pins.ceN, pins.dqOe}, 3'b010);
    arst_n = 1'b1;
    wait_reset();
    do_op(OP_READ, 20'h00010, '0, lat);
    chk(rspData, 16'hFFFF);
    t_prog(1'b0, 20'h00103, 16'h1234);
    t_prog(1'b1, 20'h12345, 16'hC0DE);
    t_page();
    t_buf();
    t_auto();
    t_erase();
    complete_run();
  end
endmodule
